// [rtai_irq_top.sv]
// rtai_irq_top: alarm comparators, periodic interrupt and 32 kHz output
//
// Behaviour
// RL1 - alarm enable bit 1 arms its alarm, 0 disarms it
// RL2 - alarm flag reads back whether its interrupt is asserted
// RL3 - writing 1 to alarm flag does nothing; 0 clears and releases output
// RL4 - clearing a flag keeps enable; next match asserts again
// RL5 - weekly compares weekday, hour, minute; daily hour and minute
// RL6 - host disables alarm while loading alarm time, then re-enables
// RL7 - enabling on the current time waits for the next match
// RL8 - select 000 keeps periodic output off; 001 holds it low
// RL9 - selects 010 and 011 give 2 Hz and 1 Hz half-duty square waves
// RL10 - selects 1xx: each second, minute, hour, or first of month
// RL11 - level mode holds output low until host writes 0 to flag
// RL12 - pulse mode increments seconds about 46 us after falling edge
// RL13 - writing seconds resets divider and drives periodic output low
// RL14 - level mode increments seconds with the falling edge
// RL15 - adjustment every 20 seconds stretches or shortens one second by 3.784 ms max
// RL16 - clock out runs when control pin high and an enable is 0
// RL17 - first clock enable at flag D3, second at enable D4, reset 0
// RL18 - periodic select sits in enable D2..D0; zero disables it
// RL19 - shared open-drain pin is low whenever any source asserts
// RL20 - alarm flag sets on match only while enabled; level event sets
// RL21 - alarm match evaluated once per minute boundary
`timescale 1ns/1ps
module rtai_irq_top #(
  parameter int OSC_PER_SEC = 32768
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic osc_pin,
  input wire logic clkout_control_pin,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic sec_wr,
  input wire logic adj_en,
  input wire logic signed [7:0] adj_delta,
  input wire logic [6:0] cur_sec,
  input wire logic [6:0] cur_min,
  input wire logic [5:0] cur_hour,
  input wire logic [2:0] cur_wday,
  input wire logic [5:0] cur_mday,
  input wire logic [6:0] alm_w_wday,
  input wire logic [5:0] alm_w_hour,
  input wire logic [6:0] alm_w_min,
  input wire logic [5:0] alm_d_hour,
  input wire logic [6:0] alm_d_min,
  output logic sec_inc,
  output logic irq_out_a_o,
  output logic irq_out_a_oe,
  output logic irq_out_b_o,
  output logic irq_out_b_oe,
  output logic irq_out_shared_o,
  output logic irq_out_shared_oe,
  output logic slow_clock_out_pin
);
  import rtai_pkg::*;

  localparam int CW = DIV_CW;
  localparam logic [CW-1:0] HALF = CW'(OSC_PER_SEC / 2);
  localparam logic [CW-1:0] QUART = CW'(OSC_PER_SEC / 4);
  localparam logic [10:0] DLY_LAST = 11'(INC_DELAY_CYC - 1);

  if (INC_DELAY_CYC < 1 || INC_DELAY_CYC > 2047) begin : g_chk
    $error("rtai_irq_top: increment delay does not fit its counter");
  end

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  logic osc_s1_q, osc_s2_q, osc_s3_q;
  logic clkout_control_pin_s1_q, clkout_control_pin_s2_q;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      clkout_control_pin_s1_q <= 1'b0;
      clkout_control_pin_s2_q <= 1'b0;
    end else begin
      osc_s1_q <= osc_pin;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      clkout_control_pin_s1_q <= clkout_control_pin;
      clkout_control_pin_s2_q <= clkout_control_pin_s1_q;
    end
  end

  // --------------------------------------------------------------------
  // sub-second divider
  // --------------------------------------------------------------------
  rtai_div_if #(.CW(CW)) dv ();

  assign dv.osc_rise = osc_s2_q & ~osc_s3_q;
  assign dv.restart = sec_wr;
  assign dv.adj_en = adj_en;
  assign dv.adj_delta = adj_delta;

  rtai_subsec_div #(.OSC_PER_SEC(OSC_PER_SEC)) u_div (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .dv(dv)
  );

  // --------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------
  logic wk_en_q, dy_en_q, clken_n2_q, clken_n1_q;
  rtai_psel_e psel_q;
  logic wr_en, wr_flag;

  assign wr_en = reg_wr && reg_addr == ADDR_CTRL_ENABLE;
  assign wr_flag = reg_wr && reg_addr == ADDR_CTRL_FLAG;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wk_en_q <= RST_ALARM_EN;
      dy_en_q <= RST_ALARM_EN;
      clken_n2_q <= RST_CLKEN_N; // RL17
      psel_q <= PS_OFF; // RL8
    end else if (wr_en) begin
      wk_en_q <= reg_wdata[BIT_WEEKLY_EN]; // RL1
      dy_en_q <= reg_wdata[BIT_DAILY_EN]; // RL1
      clken_n2_q <= reg_wdata[BIT_CLKEN_N_SECOND]; // RL17
      psel_q <= rtai_psel_e'(reg_wdata[BIT_PSEL_HI:BIT_PSEL_LO]); // RL18
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) clken_n1_q <= RST_CLKEN_N; // RL17
    else if (wr_flag) clken_n1_q <= reg_wdata[BIT_CLKEN_N_FIRST]; // RL17
  end

  // --------------------------------------------------------------------
  // second increment timing
  // --------------------------------------------------------------------
  rtai_inc_e inc_st_q;
  logic [10:0] dly_q;
  logic sec_inc_q, eval_q;
  logic pulse_mode, level_mode;

  assign pulse_mode = psel_q == PS_P2HZ || psel_q == PS_P1HZ;
  assign level_mode = psel_q[2];

  // pulse mode lags the count behind the falling edge; otherwise a read
  // right after the edge would already show the new second
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      inc_st_q <= INC_IDLE;
      dly_q <= 11'h000;
      sec_inc_q <= 1'b0;
    end else begin
      sec_inc_q <= 1'b0;
      case (inc_st_q)
        INC_IDLE: begin
          if (dv.wrap && !sec_wr) begin
            if (pulse_mode) begin
              inc_st_q <= INC_WAIT; // RL12
              dly_q <= DLY_LAST;
            end else begin
              sec_inc_q <= 1'b1; // RL14
            end
          end
        end
        INC_WAIT: begin
          if (sec_wr) begin
            inc_st_q <= INC_IDLE;
          end else if (dly_q == 11'h000) begin
            inc_st_q <= INC_IDLE;
            sec_inc_q <= 1'b1; // RL12
          end else begin
            dly_q <= dly_q - 11'h001;
          end
        end
        default: inc_st_q <= INC_IDLE;
      endcase
    end
  end

  // time inputs settle one cycle after the increment
  always_ff @(posedge clk_sys) begin
    if (!nrst) eval_q <= 1'b0;
    else eval_q <= sec_inc_q;
  end

  // --------------------------------------------------------------------
  // alarm comparators and flags
  // --------------------------------------------------------------------
  logic minute_edge, wk_match, dy_match, wk_set, dy_set;
  logic wk_flag_q, dy_flag_q;

  assign minute_edge = eval_q && cur_sec == 7'h00; // RL21
  assign wk_match = cur_wday != 3'h7 && alm_w_wday[cur_wday]
                    && cur_hour == alm_w_hour && cur_min == alm_w_min; // RL5
  assign dy_match = cur_hour == alm_d_hour && cur_min == alm_d_min; // RL5
  // a late enable cannot see the minute that already passed
  assign wk_set = minute_edge && wk_en_q && wk_match; // RL20 RL7
  assign dy_set = minute_edge && dy_en_q && dy_match; // RL20 RL7

  // set wins over a clear that lands in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wk_flag_q <= RST_FLAG;
      dy_flag_q <= RST_FLAG;
    end else begin
      if (wk_set) wk_flag_q <= 1'b1; // RL4
      else if (wr_flag && !reg_wdata[BIT_WEEKLY_FLAG]) wk_flag_q <= 1'b0; // RL3
      if (dy_set) dy_flag_q <= 1'b1; // RL4
      else if (wr_flag && !reg_wdata[BIT_DAILY_FLAG]) dy_flag_q <= 1'b0; // RL3
    end
  end

  // --------------------------------------------------------------------
  // periodic interrupt
  // --------------------------------------------------------------------
  logic lvl_event, lvl_set, per_flag_q, low_1hz, low_2hz;
  logic per_active;

  always_comb begin
    case (psel_q)
      PS_SEC: lvl_event = eval_q; // RL10
      PS_MIN: lvl_event = eval_q && cur_sec == 7'h00; // RL10
      PS_HOUR: lvl_event = eval_q && cur_sec == 7'h00
                           && cur_min == 7'h00; // RL10
      PS_MONTH: lvl_event = eval_q && cur_sec == 7'h00 && cur_min == 7'h00
                            && cur_hour == 6'h00 && cur_mday == 6'h01; // RL10
      default: lvl_event = 1'b0;
    endcase
  end

  // a seconds write in level mode also pulls the line, matching pulse mode
  assign lvl_set = lvl_event || (level_mode && sec_wr); // RL20 RL13

  always_ff @(posedge clk_sys) begin
    if (!nrst) per_flag_q <= RST_FLAG;
    else if (lvl_set) per_flag_q <= 1'b1; // RL11
    else if (wr_flag && !reg_wdata[BIT_PERIODIC_FLAG])
      per_flag_q <= 1'b0; // RL11
  end

  // the low half starts at each second boundary; adjustment lands on the
  // high half, which is the trade made for a simple compare
  assign low_1hz = dv.count < HALF; // RL9
  assign low_2hz = dv.count < QUART
                   || (dv.count >= HALF && dv.count < HALF + QUART); // RL9

  always_comb begin
    case (psel_q)
      PS_OFF: per_active = 1'b0; // RL8
      PS_LOW: per_active = 1'b1; // RL8
      PS_P2HZ: per_active = low_2hz; // RL9
      PS_P1HZ: per_active = low_1hz; // RL9
      default: per_active = per_flag_q; // RL11
    endcase
  end

  // --------------------------------------------------------------------
  // open-drain outputs, read data and clock output
  // --------------------------------------------------------------------
  logic a_oe_q, b_oe_q, sh_oe_q, clk_out_q;
  logic [7:0] rdata_q;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      a_oe_q <= 1'b0;
      b_oe_q <= 1'b0;
      sh_oe_q <= 1'b0;
    end else begin
      a_oe_q <= dy_flag_q || per_active; // RL19 RL2
      b_oe_q <= wk_flag_q; // RL2
      sh_oe_q <= dy_flag_q || per_active || wk_flag_q; // RL19
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) clk_out_q <= 1'b0;
    else clk_out_q <= osc_s2_q && clkout_control_pin_s2_q
                      && (!clken_n1_q || !clken_n2_q); // RL16
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else begin
      case (reg_addr)
        ADDR_CTRL_ENABLE: rdata_q <= {wk_en_q, dy_en_q, 1'b0, clken_n2_q,
                                      1'b0, psel_q};
        ADDR_CTRL_FLAG: rdata_q <= {4'h0, clken_n1_q, per_flag_q,
                                    wk_flag_q, dy_flag_q}; // RL2
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_q;
  assign sec_inc = sec_inc_q;
  assign irq_out_a_o = 1'b0;
  assign irq_out_b_o = 1'b0;
  assign irq_out_shared_o = 1'b0;
  assign irq_out_a_oe = a_oe_q;
  assign irq_out_b_oe = b_oe_q;
  assign irq_out_shared_oe = sh_oe_q;
  assign slow_clock_out_pin = clk_out_q;

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  alarm_set_a: assert property (minute_edge && wk_en_q && wk_match // RL20
    |=> wk_flag_q ##1 b_oe_q)
    else $error("weekly alarm match did not raise flag and pin");
  alarm_gate_a: assert property ($rose(dy_flag_q) // RL1
    |-> $past(dy_en_q) && $past(eval_q) && $past(cur_sec) == 7'h00)
    else $error("daily flag rose without enable or minute boundary");
  flag_clear_a: assert property (wr_flag && !reg_wdata[BIT_DAILY_FLAG] // RL3
    && !dy_set |=> !dy_flag_q)
    else $error("writing zero did not clear daily flag");
  flag_one_a: assert property (wr_flag && reg_wdata[BIT_WEEKLY_FLAG] // RL3
    && !wk_flag_q && !wk_set |=> !wk_flag_q)
    else $error("writing one changed weekly flag");
  keep_enable_a: assert property (wr_flag && !wr_en // RL4
    |=> $stable(wk_en_q) && $stable(dy_en_q))
    else $error("flag write disturbed alarm enables");
  read_flag_a: assert property (!reg_wr ##1 reg_addr == ADDR_CTRL_FLAG // RL2
    |=> reg_rdata[BIT_WEEKLY_FLAG] == $past(wk_flag_q))
    else $error("flag readback mismatch");
  off_quiet_a: assert property ((psel_q == PS_OFF && !dy_flag_q)[*2] // RL8
    |-> !irq_out_a_oe)
    else $error("periodic off but pin driven");
  fixed_low_a: assert property ((psel_q == PS_LOW)[*2] |-> irq_out_a_oe) // RL8
    else $error("fixed low select but pin released");
  pulse_wait_a: assert property (inc_st_q == INC_IDLE && dv.wrap // RL12
    && !sec_wr && pulse_mode |=> inc_st_q == INC_WAIT && dly_q == DLY_LAST)
    else $error("pulse mode increment not delayed");
  pulse_fire_a: assert property (inc_st_q == INC_WAIT // RL12
    && dly_q == 11'h000 && !sec_wr |=> sec_inc_q && inc_st_q == INC_IDLE)
    else $error("delayed increment missing");
  level_inc_a: assert property (inc_st_q == INC_IDLE && dv.wrap // RL14
    && !sec_wr && !pulse_mode |=> sec_inc_q)
    else $error("level mode increment not at the edge");
  level_hold_a: assert property (per_flag_q // RL11
    && !(wr_flag && !reg_wdata[BIT_PERIODIC_FLAG]) |=> per_flag_q)
    else $error("periodic flag dropped without a clear");
  sec_write_a: assert property (sec_wr && psel_q != PS_OFF // RL13
    && !wr_en |-> ##2 irq_out_a_oe)
    else $error("seconds write did not pull periodic output low");
  clk_gate_a: assert property (!clkout_control_pin_s2_q // RL16
    || (clken_n1_q && clken_n2_q) |=> !slow_clock_out_pin)
    else $error("clock output ran while gated");

  wk_fire_c: cover property (wk_set ##1 wk_flag_q);
  lvl_clear_c: cover property (per_flag_q ##1 !per_flag_q);
  // the delay counter itself spans the long wait
  pulse_inc_c: cover property (inc_st_q == INC_WAIT && dly_q == 11'h000
    ##1 sec_inc_q);
  clk_run_c: cover property ($rose(slow_clock_out_pin));

endmodule // rtai_irq_top

// [rtai_pkg.sv]
// rtai_pkg: constants and types of the alarm, periodic irq and clock output
package rtai_pkg;

  // ---------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL_ENABLE = 4'hE;
  localparam logic [3:0] ADDR_CTRL_FLAG = 4'hF;

  // ctrl_enable_reg fields
  localparam int BIT_WEEKLY_EN = 7;
  localparam int BIT_DAILY_EN = 6;
  localparam int BIT_CLKEN_N_SECOND = 4;
  localparam int BIT_PSEL_HI = 2;
  localparam int BIT_PSEL_LO = 0;

  // ctrl_flag_reg fields
  localparam int BIT_CLKEN_N_FIRST = 3;
  localparam int BIT_PERIODIC_FLAG = 2;
  localparam int BIT_WEEKLY_FLAG = 1;
  localparam int BIT_DAILY_FLAG = 0;

  // values after reset
  localparam logic RST_ALARM_EN = 1'b0;
  localparam logic RST_CLKEN_N = 1'b0;
  localparam logic RST_FLAG = 1'b0;

  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int SYS_CLK_MHZ = 25;
  localparam int OSC_HZ = 32768;
  localparam int INC_DELAY_NS = 46000;
  localparam int INC_DELAY_CYC = (INC_DELAY_NS * SYS_CLK_MHZ) / 1000;
  localparam int ADJ_PERIOD_SEC = 20;
  localparam int ADJ_MAX_US = 3784;
  localparam int ADJ_MAX_OSC = (ADJ_MAX_US * OSC_HZ) / 1000000;
  localparam int DIV_CW = 17;

  // ---------------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    PS_OFF = 3'b000,
    PS_LOW = 3'b001,
    PS_P2HZ = 3'b010,
    PS_P1HZ = 3'b011,
    PS_SEC = 3'b100,
    PS_MIN = 3'b101,
    PS_HOUR = 3'b110,
    PS_MONTH = 3'b111
  } rtai_psel_e;

  typedef enum logic [0:0] {
    INC_IDLE = 1'b0,
    INC_WAIT = 1'b1
  } rtai_inc_e;

endpackage

// [rtai_div_if.sv]
// rtai_div_if: link between the control logic and the sub-second divider
`timescale 1ns/1ps
interface rtai_div_if #(parameter int CW = 17);
  logic osc_rise;
  logic restart;
  logic adj_en;
  logic signed [7:0] adj_delta;
  logic wrap;
  logic [CW-1:0] count;

  modport div (input osc_rise, input restart, input adj_en,
               input adj_delta, output wrap, output count);
  modport ctl (output osc_rise, output restart, output adj_en,
               output adj_delta, input wrap, input count);
endinterface

// [rtai_subsec_div.sv]
// rtai_subsec_div: oscillator-edge divider down to the one-second boundary
`timescale 1ns/1ps
module rtai_subsec_div #(
  parameter int OSC_PER_SEC = 32768
) (
  input wire logic clk_sys,
  input wire logic nrst,
  rtai_div_if.div dv
);
  import rtai_pkg::*;

  localparam int CW = $bits(dv.count);
  localparam logic signed [CW+1:0] BASE_TERM = (CW+2)'(OSC_PER_SEC - 1);
  localparam logic signed [7:0] DMAX = 8'(ADJ_MAX_OSC);

  if (OSC_PER_SEC < 8 || OSC_PER_SEC + ADJ_MAX_OSC >= 2 ** CW) begin : g_chk
    $error("rtai_subsec_div: OSC_PER_SEC out of range for divider width");
  end

  logic [4:0] sec20_q;
  logic [CW-1:0] count_q;
  logic wrap_q;
  logic signed [7:0] delta_c;
  logic signed [CW+1:0] term_s;
  logic [CW-1:0] term;

  // adjustment is clamped so one corrected second never moves too far
  always_comb begin
    if (dv.adj_delta > DMAX) delta_c = DMAX;
    else if (dv.adj_delta < -DMAX) delta_c = -DMAX;
    else delta_c = dv.adj_delta;
    term_s = BASE_TERM;
    if (dv.adj_en && sec20_q == 5'(ADJ_PERIOD_SEC - 1)) begin // RL15
      term_s = BASE_TERM + (CW+2)'(delta_c);
    end
    term = term_s[CW-1:0];
  end

  // --------------------------------------------------------------------
  // divider stage, cleared by a second-counter write; the 20-second count is not
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst || dv.restart) begin // RL13
      count_q <= '0;
      wrap_q <= 1'b0;
    end else begin
      wrap_q <= 1'b0;
      if (dv.osc_rise) begin
        if (count_q >= term) begin
          count_q <= '0;
          wrap_q <= 1'b1;
        end else begin
          count_q <= count_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sec20_q <= 5'h00;
    end else if (wrap_q) begin
      if (sec20_q == 5'(ADJ_PERIOD_SEC - 1)) sec20_q <= 5'h00;
      else sec20_q <= sec20_q + 5'h01;
    end
  end

  assign dv.wrap = wrap_q;
  assign dv.count = count_q;

  wrap_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst) // RL15
    dv.osc_rise && !dv.restart && count_q >= term
    |=> wrap_q && count_q == '0)
    else $error("divider missed its terminal count");

endmodule // rtai_subsec_div

// [rtai_time_model.sv]
// rtai_time_model: crystal and bcd time counters beside the block
`timescale 1ns/1ps
module rtai_time_model (
  input wire logic clk_sys,
  input wire logic sec_inc,
  input wire logic load,
  input wire logic [22:0] ld_time,
  input wire logic [5:0] ld_mday,
  output logic osc_pin,
  output logic [6:0] cur_sec,
  output logic [6:0] cur_min,
  output logic [5:0] cur_hour,
  output logic [2:0] cur_wday,
  output logic [5:0] cur_mday
);
  function automatic logic [6:0] bcd_inc(input logic [6:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[6:4] + 3'h1, 4'h0} : v + 7'h01;
  endfunction

  // crystal runs free, phase offset keeps it unrelated to clk_sys
  initial begin
    osc_pin = 1'b0;
    #37;
    forever #160 osc_pin = ~osc_pin;
  end

  // days never roll over: the bench presets the day of month itself
  always_ff @(posedge clk_sys) begin
    if (load) begin
      {cur_wday, cur_hour, cur_min, cur_sec} <= ld_time;
      cur_mday <= ld_mday;
    end else if (sec_inc) begin
      cur_sec <= (cur_sec == 7'h59) ? 7'h00 : bcd_inc(cur_sec);
      if (cur_sec == 7'h59) begin
        cur_min <= (cur_min == 7'h59) ? 7'h00 : bcd_inc(cur_min);
        if (cur_min == 7'h59) begin
          cur_hour <= (cur_hour == 6'h23) ? 6'h00 :
                      6'(bcd_inc({1'b0, cur_hour}));
        end
      end
    end
  end
endmodule // rtai_time_model

// [tb.sv]
// tb: self-checking bench of the alarm, periodic irq and clock output
`timescale 1ns/1ps
module tb;
  import rtai_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic clk_ctl = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic sec_wr = 1'b0;
  logic load = 1'b1;
  logic [22:0] ld_time = 23'h00_0010;
  logic [5:0] ld_mday = 6'h01;
  logic [5:0] al_hour = 6'h3F;
  logic [6:0] al_min = 7'h7F;
  logic [7:0] reg_rdata;
  logic [6:0] cur_sec, cur_min;
  logic [5:0] cur_hour, cur_mday;
  logic [2:0] cur_wday;
  logic osc_pin, sec_inc, a_oe, b_oe, s_oe, clk_out, a_o, b_o, s_o;
  logic adj_en = 1'b0;
  logic signed [7:0] adj_delta = 8'sd16;
  int inc_count = 0;
  int fail_count = 0;
  int checked = 0;

  always #20 clk_sys = ~clk_sys;

  // seconds since reset, to find the stretched 20th second
  always @(posedge clk_sys) begin
    if (sec_inc === 1'b1) inc_count++;
  end

  rtai_time_model u_time (.clk_sys(clk_sys), .sec_inc(sec_inc),
    .load(load), .ld_time(ld_time), .ld_mday(ld_mday), .osc_pin(osc_pin),
    .cur_sec(cur_sec), .cur_min(cur_min), .cur_hour(cur_hour),
    .cur_wday(cur_wday), .cur_mday(cur_mday));

  rtai_irq_top #(.OSC_PER_SEC(256)) u_dut (.clk_sys(clk_sys),
    .nrst(nrst), .osc_pin(osc_pin), .clkout_control_pin(clk_ctl),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .sec_wr(sec_wr), .adj_en(adj_en),
    .adj_delta(adj_delta), .cur_sec(cur_sec), .cur_min(cur_min),
    .cur_hour(cur_hour), .cur_wday(cur_wday), .cur_mday(cur_mday),
    .alm_w_wday(7'h04), .alm_w_hour(al_hour), .alm_w_min(al_min),
    .alm_d_hour(al_hour), .alm_d_min(al_min), .sec_inc(sec_inc),
    .irq_out_a_o(a_o), .irq_out_a_oe(a_oe), .irq_out_b_o(b_o),
    .irq_out_b_oe(b_oe), .irq_out_shared_o(s_o), .irq_out_shared_oe(s_oe),
    .slow_clock_out_pin(clk_out));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask

  task automatic wait_inc();
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (sec_inc !== 1'b1 && n < 5000);
    chk({7'h00, sec_inc}, 8'h01);
  endtask

  task automatic preset(input logic [22:0] t, input logic [5:0] md);
    @(negedge clk_sys);
    ld_time = t;
    ld_mday = md;
    load = 1'b1;
    @(negedge clk_sys);
    load = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] d;
    rd(4'hE, d);
    chk(d, 8'h00);
    rd(4'hF, d);
    chk(d, 8'h00);
    wr(4'hE, 8'hFF);
    rd(4'hE, d);
    chk(d, 8'hD7);
    wr(4'h3, 8'hFF);
    rd(4'h3, d);
    chk(d, 8'h00);
    wr(4'hE, 8'h00);
  endtask

  // counts rising edges of the clock output over 50 crystal periods
  task automatic t_clk(input logic [7:0] e, input logic [7:0] f,
                       input logic c, input logic on);
    int n;
    logic prev;
    wr(4'hE, e);
    wr(4'hF, f);
    clk_ctl = c;
    repeat (10) @(negedge clk_sys);
    n = 0;
    prev = clk_out;
    repeat (400) begin
      @(negedge clk_sys);
      if (clk_out === 1'b1 && prev === 1'b0) n++;
      prev = clk_out;
    end
    chk({7'h00, n > 40}, {7'h00, on});
    chk({7'h00, n == 0}, {7'h00, !on});
  endtask

  task automatic t_fixed();
    wr(4'hE, 8'h01);
    repeat (4) @(negedge clk_sys);
    chk({5'h00, a_oe, b_oe, s_oe}, 8'h05);
    chk({5'h00, a_o, b_o, s_o}, 8'h00);
    wr(4'hE, 8'h00);
    repeat (4) @(negedge clk_sys);
    chk({5'h00, a_oe, b_oe, s_oe}, 8'h00);
  endtask

  task automatic t_level();
    logic [7:0] d;
    logic ex;
    for (int t = 0; t < 3; t++) begin
      for (int s = 4; s < 8; s++) begin
        ex = (s == 4) || (t >= 1 && s <= 6) || (t == 2);
        wr(4'hE, 8'(s));
        wait_inc();
        repeat (10) @(negedge clk_sys);
        preset(t == 0 ? {3'd1, 6'h12, 7'h34, 7'h56} :
               {3'd1, 6'h23, 7'h59, 7'h59}, t == 2 ? 6'h01 : 6'h02);
        wr(4'hF, 8'h00);
        wait_inc();
        repeat (5) @(negedge clk_sys);
        chk({7'h00, a_oe}, {7'h00, ex});
        rd(4'hF, d);
        chk(d & 8'h04, ex ? 8'h04 : 8'h00);
        wr(4'hF, 8'h04);
        chk({7'h00, a_oe}, {7'h00, ex});
        wr(4'hF, 8'h00);
        repeat (3) @(negedge clk_sys);
        chk({7'h00, a_oe}, 8'h00);
      end
    end
  endtask

  task automatic t_pulse(input logic [7:0] sel, input int lo);
    int n;
    wr(4'hE, sel);
    @(negedge clk_sys);
    sec_wr = 1'b1;
    @(negedge clk_sys);
    sec_wr = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk({7'h00, a_oe}, 8'h01);
    for (int ph = 0; ph < 2; ph++) begin
      n = 0;
      while (a_oe === (ph == 0) && n < 3000) begin
        @(negedge clk_sys);
        n++;
      end
      chk({7'h00, n > lo - 12 && n < lo + 12}, 8'h01);
    end
    if (lo == 1024) begin
      n = 0;
      while (sec_inc !== 1'b1 && n < 3000) begin
        @(negedge clk_sys);
        n++;
      end
      chk({7'h00, n > 1143 && n < 1157}, 8'h01);
    end
  endtask

  task automatic t_alarm();
    logic [7:0] d;
    logic [7:0] en_t[4] = '{8'h00, 8'h40, 8'hC0, 8'hC0};
    logic [2:0] wd_t[4] = '{3'd2, 3'd2, 3'd3, 3'd2};
    logic [1:0] ex_t[4] = '{2'b00, 2'b01, 2'b01, 2'b11};
    wr(4'hE, 8'h00);
    al_hour = 6'h10;
    al_min = 7'h30;
    for (int i = 0; i < 4; i++) begin
      wr(4'hE, en_t[i]);
      wait_inc();
      repeat (10) @(negedge clk_sys);
      preset({wd_t[i], 6'h10, 7'h29, 7'h59}, 6'h02);
      wait_inc();
      repeat (6) @(negedge clk_sys);
      rd(4'hF, d);
      chk(d, {6'h00, ex_t[i]});
      chk({5'h00, a_oe, b_oe, s_oe},
          {5'h00, ex_t[i][0], ex_t[i][1], |ex_t[i]});
      wr(4'hF, 8'h0B);
      rd(4'hF, d);
      chk(d, {6'h02, ex_t[i]});
      wr(4'hF, 8'h00);
      repeat (3) @(negedge clk_sys);
      chk({5'h00, a_oe, b_oe, s_oe}, 8'h00);
      rd(4'hE, d);
      chk(d, en_t[i]);
    end
    wait_inc();
    repeat (6) @(negedge clk_sys);
    rd(4'hF, d);
    chk(d, 8'h00);
  endtask

  // seconds write in level mode, then the stretched 20th second
  task automatic t_adjust();
    int n;
    int lo;
    wr(4'hE, 8'h04);
    @(negedge clk_sys);
    sec_wr = 1'b1;
    @(negedge clk_sys);
    sec_wr = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk({7'h00, a_oe}, 8'h01);
    wr(4'hE, 8'h00);
    wr(4'hF, 8'h00);
    adj_en = 1'b1;
    do begin
      wait_inc();
      @(negedge clk_sys);
    end while (inc_count % 20 != 19);
    for (int k = 0; k < 2; k++) begin
      lo = (k == 0) ? 2176 : 2048;
      n = 0;
      do begin
        @(negedge clk_sys);
        n++;
      end while (sec_inc !== 1'b1 && n < 5000);
      chk({7'h00, n > lo - 16 && n < lo + 16}, 8'h01);
    end
  endtask

  initial begin
    repeat (6) @(negedge clk_sys);
    nrst = 1'b1;
    load = 1'b0;
    t_regs();
    t_clk(8'h00, 8'h00, 1'b1, 1'b1);
    t_clk(8'h10, 8'h00, 1'b1, 1'b1);
    t_clk(8'h00, 8'h08, 1'b1, 1'b1);
    t_clk(8'h10, 8'h08, 1'b1, 1'b0);
    t_clk(8'h00, 8'h00, 1'b0, 1'b0);
    t_fixed();
    t_level();
    t_pulse(8'h02, 512);
    t_pulse(8'h03, 1024);
    t_alarm();
    t_adjust();
    end_sim();
  end

  // whole run is about 85000 cycles
  initial begin
    repeat (98000) @(posedge clk_sys);
    fail_count++;
    end_sim();
  end
endmodule // tb
